// file: fpc_pkg.sv
// constants and types shared by the fractional pll configuration block
package fpc_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_PLL_ON = 8'h04;
   localparam logic [7:0] OFF_SRC_SEL = 8'h0D;
   localparam logic [7:0] OFF_P_DIV = 8'h14;
   localparam logic [7:0] OFF_J_MUL = 8'h15;
   localparam logic [7:0] OFF_D_HIGH = 8'h16;
   localparam logic [7:0] OFF_D_LOW = 8'h17;
   localparam logic [7:0] OFF_R_MUL = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h7F;
   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int SRC_LSB = 4;
   localparam int SRC_MSB = 6;
   localparam logic RST_PLL_ON = 1'h1;
   localparam logic [2:0] RST_SRC_SEL = 3'h0;
   localparam logic [3:0] RST_P_DIV = 4'h1;
   localparam logic [5:0] RST_J_MUL = 6'h08;
   localparam logic [5:0] RST_D_HIGH = 6'h00;
   localparam logic [7:0] RST_D_LOW = 8'h00;
   localparam logic [3:0] RST_R_MUL = 4'h0;
   localparam logic [2:0] SRC_MCLK = 3'h0;
   localparam logic [2:0] SRC_BCLK = 3'h1;
   localparam logic [2:0] SRC_GPIO = 3'h3;
   // ----------------------------------------------------------------
   // widths, scales and legal ranges
   // ----------------------------------------------------------------
   localparam int FIN_W = 26;
   localparam int DIV_W = 7;
   localparam int CLK_SYS_HZ = 40_000_000;
   localparam logic [19:0] K_SCALE = 20'h02710;
   localparam logic [13:0] D_MAX = 14'h270F;
   localparam int FS_SHIFT = 11;
   localparam logic [11:0] PLL_FS_RATIO = 12'h800;
   localparam logic [5:0] J_MIN_INT = 6'h01;
   localparam logic [5:0] J_MAX_INT = 6'h3F;
   localparam logic [5:0] J_MIN_FRAC = 6'h04;
   localparam logic [5:0] J_MAX_FRAC = 6'h0B;
   localparam logic [63:0] REF_MIN_INT_HZ = 64'h00000000000F4240;
   localparam logic [63:0] REF_MIN_FRAC_HZ = 64'h000000000065BAF8;
   localparam logic [63:0] REF_MAX_HZ = 64'h0000000001312D00;
   localparam logic [31:0] VCO_MIN_HZ = 32'h03D09000;
   localparam logic [31:0] VCO_MAX_HZ = 32'h05F5E100;
   // ----------------------------------------------------------------
   // control port states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      I_IDLE = 4'b0000, I_ADDR = 4'b0001, I_ACKA = 4'b0010,
      I_PTR = 4'b0011, I_ACKP = 4'b0100, I_WDAT = 4'b0101,
      I_ACKW = 4'b0110, I_RDAT = 4'b0111, I_RACK = 4'b1000
   } fpc_i2c_state_type;
endpackage

// file: fpc_i2c_regport.sv
// two-wire control port slave with register pointer and auto increment
`timescale 1ns/1ps
`default_nettype none
module fpc_i2c_regport #(
   parameter logic [6:0] DEV_ADDR = 7'h4A
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic sclS,
   input wire logic sdaS,
   input wire logic [7:0] rdData,
   output logic [7:0] regPtr,
   output logic wrStrobe,
   output logic [7:0] wrData,
   output logic sdaOeN
);
   import fpc_pkg::*;
   fpc_i2c_state_type state;
   logic sclD, sdaD, rwBit;
   logic [3:0] bitCnt;
   logic [7:0] shiftReg;
   // ----------------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------------
   wire sclRise = sclS & ~sclD;
   wire sclFall = ~sclS & sclD;
   wire startCond = sclS & sclD & sdaD & ~sdaS;
   wire stopCond = sclS & sclD & ~sdaD & sdaS;
   wire byteDone = (bitCnt == 4'h8);
   wire addrHit = (shiftReg[7:1] == DEV_ADDR);
   wire inShift = (state == I_ADDR) | (state == I_PTR) | (state == I_WDAT);
   // ----------------------------------------------------------------
   // sequencer: sample on rising scl, drive on falling scl
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state <= I_IDLE;
         sclD <= 1'b1;
         sdaD <= 1'b1;
         rwBit <= 1'b0;
         bitCnt <= 4'h0;
         shiftReg <= 8'h00;
         regPtr <= 8'h00;
         wrStrobe <= 1'b0;
         wrData <= 8'h00;
         sdaOeN <= 1'b1;
      end
      else
      begin
         sclD <= sclS;
         sdaD <= sdaS;
         wrStrobe <= 1'b0;
         if (startCond)
         begin
            state <= I_ADDR;
            bitCnt <= 4'h0;
            sdaOeN <= 1'b1;
         end
         else if (stopCond)
         begin
            state <= I_IDLE;
            sdaOeN <= 1'b1;
         end
         else if (sclRise)
         begin
            if (inShift)
               shiftReg <= {shiftReg[6:0], sdaS};
            if (inShift || state == I_RDAT)
               bitCnt <= bitCnt + 4'h1;
            // no ack from the master ends the read burst
            if (state == I_RACK && sdaS)
               state <= I_IDLE;
         end
         else if (sclFall)
         begin
            unique case (state)
               I_IDLE: ;
               I_ADDR:
                  if (byteDone)
                  begin
                     state <= addrHit ? I_ACKA : I_IDLE;
                     sdaOeN <= ~addrHit;
                     rwBit <= shiftReg[0];
                  end
               I_ACKA:
               begin
                  bitCnt <= 4'h0;
                  shiftReg <= rdData;
                  sdaOeN <= rwBit ? rdData[7] : 1'b1;
                  state <= rwBit ? I_RDAT : I_PTR;
               end
               I_PTR:
                  if (byteDone)
                  begin
                     regPtr <= shiftReg;
                     sdaOeN <= 1'b0;
                     state <= I_ACKP;
                  end
               I_ACKP:
               begin
                  bitCnt <= 4'h0;
                  sdaOeN <= 1'b1;
                  state <= I_WDAT;
               end
               I_WDAT:
                  if (byteDone)
                  begin
                     wrData <= shiftReg;
                     wrStrobe <= 1'b1;
                     sdaOeN <= 1'b0;
                     state <= I_ACKW;
                  end
               I_ACKW:
               begin
                  bitCnt <= 4'h0;
                  regPtr <= regPtr + 8'h01;
                  sdaOeN <= 1'b1;
                  state <= I_WDAT;
               end
               I_RDAT:
                  if (byteDone)
                  begin
                     sdaOeN <= 1'b1;
                     regPtr <= regPtr + 8'h01;
                     state <= I_RACK;
                  end
                  else
                  begin
                     shiftReg <= {shiftReg[6:0], 1'b0};
                     sdaOeN <= shiftReg[6];
                  end
               I_RACK:
               begin
                  bitCnt <= 4'h0;
                  shiftReg <= rdData;
                  sdaOeN <= rdData[7];
                  state <= I_RDAT;
               end
               default: state <= I_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: fpc_pll_config.sv
// fractional pll configuration registers, reference divider and rate checks
`timescale 1ns/1ps
`default_nettype none
module fpc_pll_config #(
   parameter logic [6:0] DEV_ADDR = 7'h4A
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sclPin,
   input wire logic sdaPin,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic masterClockPin,
   input wire logic bitClockPin,
   input wire logic gpioClockPin,
   input wire logic [fpc_pkg::FIN_W-1:0] pllInputClockHz,
   input wire logic [fpc_pkg::DIV_W-1:0] processingClockDivider,
   input wire logic [fpc_pkg::DIV_W-1:0] dacClockDivider,
   input wire logic [fpc_pkg::DIV_W-1:0] oversamplingClockDivider,
   input wire logic [fpc_pkg::DIV_W-1:0] chargePumpClockDivider,
   input wire logic clockMaster,
   output logic pllOn,
   output logic [2:0] referenceSourceSelect,
   output logic [3:0] preDividerP,
   output logic [5:0] integerMultiplierJ,
   output logic [13:0] fractionMultiplierD,
   output logic [3:0] extraMultiplierR,
   output logic pllRefTick,
   output logic [24:0] multiplierKR,
   output logic [31:0] pllOutputClockHz,
   output logic [31:0] sampleRateHz,
   output logic [11:0] dspRatio,
   output logic [11:0] modRatio,
   output logic [31:0] chargePumpClockHz,
   output logic configLegal,
   output logic rateMismatch,
   output logic osrMatch
);
   import fpc_pkg::*;
   logic rstMeta, rstSyncN;
   logic [4:0] pinMeta, pinSync;
   logic [5:0] dHighReg;
   logic [7:0] dLowReg;
   logic refLast;
   logic [3:0] edgeCnt;
   logic [7:0] regPtr, wrData, rdData;
   logic wrStrobe;
   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta <= 1'b0;
         rstSyncN <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   // limitation: a reference above 20 MHz is undersampled here
   always_ff @(posedge clk_sys or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         pinMeta <= 5'h03;
         pinSync <= 5'h03;
      end
      else
      begin
         pinMeta <= {gpioClockPin, bitClockPin, masterClockPin, sdaPin, sclPin};
         pinSync <= pinMeta;
      end
   end
   // ----------------------------------------------------------------
   // control port and register file
   // ----------------------------------------------------------------
   fpc_i2c_regport #(.DEV_ADDR(DEV_ADDR)) uPort (
      .clk(clk_sys),
      .rstN(rstSyncN),
      .sclS(pinSync[0]),
      .sdaS(pinSync[1]),
      .rdData(rdData),
      .regPtr(regPtr),
      .wrStrobe(wrStrobe),
      .wrData(wrData),
      .sdaOeN(sdaOeN)
   );

   wire wrPllOn = wrStrobe && (regPtr == OFF_PLL_ON);
   wire wrSrc = wrStrobe && (regPtr == OFF_SRC_SEL);
   wire wrP = wrStrobe && (regPtr == OFF_P_DIV);
   wire wrJ = wrStrobe && (regPtr == OFF_J_MUL);
   wire wrDHigh = wrStrobe && (regPtr == OFF_D_HIGH);
   wire wrDLow = wrStrobe && (regPtr == OFF_D_LOW);
   wire wrR = wrStrobe && (regPtr == OFF_R_MUL);
   wire [7:0] statusByte = {4'h0, osrMatch, rateMismatch, fractionMultiplierD != 14'h0,
      configLegal};
   // reserved bits and unmapped offsets read as zero
   assign rdData = (regPtr == OFF_PLL_ON) ? {7'h00, pllOn} :
      (regPtr == OFF_SRC_SEL) ? {1'b0, referenceSourceSelect, 4'h0} :
      (regPtr == OFF_P_DIV) ? {4'h0, preDividerP} :
      (regPtr == OFF_J_MUL) ? {2'h0, integerMultiplierJ} :
      (regPtr == OFF_D_HIGH) ? {2'h0, dHighReg} :
      (regPtr == OFF_D_LOW) ? dLowReg :
      (regPtr == OFF_R_MUL) ? {4'h0, extraMultiplierR} :
      (regPtr == OFF_STATUS) ? statusByte : 8'h00;

   always_ff @(posedge clk_sys or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         pllOn <= RST_PLL_ON;
         referenceSourceSelect <= RST_SRC_SEL;
         preDividerP <= RST_P_DIV;
         integerMultiplierJ <= RST_J_MUL;
         dHighReg <= RST_D_HIGH;
         dLowReg <= RST_D_LOW;
         extraMultiplierR <= RST_R_MUL;
      end
      else
      begin
         if (wrPllOn) pllOn <= wrData[0];
         if (wrSrc) referenceSourceSelect <= wrData[SRC_MSB:SRC_LSB];
         if (wrP) preDividerP <= wrData[3:0];
         if (wrJ) integerMultiplierJ <= wrData[5:0];
         if (wrDHigh) dHighReg <= wrData[5:0];
         if (wrDLow) dLowReg <= wrData;
         if (wrR) extraMultiplierR <= wrData[3:0];
      end
   end

   assign fractionMultiplierD = {dHighReg, dLowReg};
   assign sdaOut = 1'b0;
   // ----------------------------------------------------------------
   // reference selection and divide by P
   // ----------------------------------------------------------------
   wire refSel = (referenceSourceSelect == SRC_BCLK) ? pinSync[3] :
      (referenceSourceSelect == SRC_GPIO) ? pinSync[4] : pinSync[2];
   wire refEdge = refSel & ~refLast;
   wire [3:0] pSafe = (preDividerP == 4'h0) ? 4'h1 : preDividerP;
   wire [3:0] pMinus1 = pSafe - 4'h1;

   always_ff @(posedge clk_sys or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         refLast <= 1'b0;
         edgeCnt <= 4'h0;
         pllRefTick <= 1'b0;
      end
      else
      begin
         refLast <= refSel;
         pllRefTick <= pllOn & refEdge & (edgeCnt >= pMinus1);
         if (pllOn & refEdge)
            edgeCnt <= (edgeCnt >= pMinus1) ? 4'h0 : edgeCnt + 4'h1;
      end
   end
   // ----------------------------------------------------------------
   // rate arithmetic: K scaled by 10000 keeps the four-digit fraction exact
   // ----------------------------------------------------------------
   wire fracMode = (fractionMultiplierD != 14'h0);
   wire [4:0] rValue = {1'b0, extraMultiplierR} + 5'h01;
   wire [19:0] kTimes10k = {14'h0, integerMultiplierJ} * K_SCALE
      + {6'h0, fractionMultiplierD};
   wire [24:0] mTimes10k = {5'h0, kTimes10k} * {20'h0, rValue};
   wire [63:0] finW = {{(64 - FIN_W){1'b0}}, pllInputClockHz};
   wire [63:0] pW = {60'h0, pSafe};
   wire [63:0] vcoQuot = (finW * {39'h0, mTimes10k}) / (pW * {44'h0, K_SCALE});
   wire [6:0] nmacSafe = (processingClockDivider == 7'h0) ? 7'h01 : processingClockDivider;
   wire [6:0] ndacSafe = (dacClockDivider == 7'h0) ? 7'h01 : dacClockDivider;
   wire [6:0] ncpSafe = (chargePumpClockDivider == 7'h0) ? 7'h01 : chargePumpClockDivider;
   wire [63:0] cpQuot = ({32'h0, sampleRateHz} * {52'h0, modRatio})
      / {57'h0, ncpSafe};

   // checks of what software must keep, shown in the status register
   wire [63:0] refMin = fracMode ? REF_MIN_FRAC_HZ : REF_MIN_INT_HZ;
   wire refOk = (finW >= refMin * pW) && (finW <= REF_MAX_HZ * pW);
   wire vcoOk = (vcoQuot >= {32'h0, VCO_MIN_HZ}) && (vcoQuot <= {32'h0, VCO_MAX_HZ});
   wire jOk = fracMode ? (integerMultiplierJ >= J_MIN_FRAC && integerMultiplierJ <= J_MAX_FRAC)
      : (integerMultiplierJ >= J_MIN_INT && integerMultiplierJ <= J_MAX_INT);
   wire rOk = !fracMode || (extraMultiplierR == 4'h0);
   wire fieldOk = (preDividerP != 4'h0) && (fractionMultiplierD <= D_MAX);

   always_ff @(posedge clk_sys or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         multiplierKR <= 25'h0;
         pllOutputClockHz <= 32'h0;
         sampleRateHz <= 32'h0;
         dspRatio <= 12'h0;
         modRatio <= 12'h0;
         chargePumpClockHz <= 32'h0;
         configLegal <= 1'b0;
         rateMismatch <= 1'b0;
         osrMatch <= 1'b0;
      end
      else
      begin
         multiplierKR <= mTimes10k;
         pllOutputClockHz <= pllOn ? vcoQuot[31:0] : 32'h0;
         sampleRateHz <= pllOutputClockHz >> FS_SHIFT;
         dspRatio <= PLL_FS_RATIO / {5'h0, nmacSafe};
         modRatio <= PLL_FS_RATIO / {5'h0, ndacSafe};
         chargePumpClockHz <= cpQuot[31:0];
         configLegal <= !pllOn || (refOk && vcoOk && jOk && rOk && fieldOk);
         rateMismatch <= pllOn && clockMaster && (pllOutputClockHz[10:0] != 11'h0);
         osrMatch <= (modRatio == {1'b0, oversamplingClockDivider, 4'h0});
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_pll_on_reset: assert property (@(posedge clk_sys) $rose(rstSyncN) |-> pllOn)
      else $error("pll enable not set after reset");

   // field captures: each write lands in the cycle after the strobe
   a_enable_write: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      wrPllOn |=> pllOn == $past(wrData[0]))
      else $error("pll enable field not captured");
   a_p_field_write: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      wrP |=> preDividerP == $past(wrData[3:0]))
      else $error("pre divider field not captured");
   a_j_field_write: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      wrJ |=> integerMultiplierJ == $past(wrData[5:0]))
      else $error("integer multiplier field not captured");
   a_r_field_write: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      wrR |=> extraMultiplierR == $past(wrData[3:0]))
      else $error("extra multiplier field not captured");
   a_src_field_write: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      wrSrc |=> referenceSourceSelect == $past(wrData[6:4]))
      else $error("reference source field not captured");

   a_d_low_concat: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      wrDLow && !wrDHigh |=> fractionMultiplierD == {$past(dHighReg), $past(wrData)})
      else $error("fraction value not concatenated");
   a_d_high_concat: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      wrDHigh && !wrDLow |=> fractionMultiplierD[13:8] == $past(wrData[5:0]))
      else $error("fraction high field not concatenated");

   a_mult_integer_r: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      (extraMultiplierR == 4'h1 && fractionMultiplierD == 14'h0 && $stable(integerMultiplierJ))
      |=> multiplierKR == 25'($past(integerMultiplierJ)) * 25'(K_SCALE) * 25'h2)
      else $error("k times r wrong");

   a_ref_tick_count: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      pllOn && refEdge && edgeCnt == pMinus1 |=> pllRefTick && edgeCnt == 4'h0)
      else $error("reference divide by p wrong");
   a_tick_needs_on: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      pllRefTick |-> $past(pllOn))
      else $error("reference tick while pll disabled");

   a_fs_from_vco: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      pllOn [*3] |-> sampleRateHz == ($past(pllOutputClockHz) >> 11))
      else $error("sample rate not vco over 2048");
   a_pll_off_idle: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      !pllOn [*3] |-> pllOutputClockHz == 32'h0 && sampleRateHz == 32'h0)
      else $error("pll rates not zero while disabled");
   a_legal_when_off: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      !pllOn |=> configLegal)
      else $error("config not legal while pll disabled");

   // three cycles skip the edge at which the ratio flops still sit in reset
   a_dsp_ratio_12: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      (processingClockDivider == 7'h0C) [*3] |-> dspRatio == 12'h0AA)
      else $error("processing ratio wrong");
   a_dac_ratio_16: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      (dacClockDivider == 7'h10) [*3] |-> modRatio == 12'h080)
      else $error("dac ratio wrong");

   a_cp_relation: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      (chargePumpClockDivider == 7'h01) [*2] ##0 ($stable(sampleRateHz) && $stable(modRatio))
      |-> chargePumpClockHz == 32'(sampleRateHz * modRatio))
      else $error("charge pump rate wrong");

   a_mismatch_slave: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      !clockMaster |=> !rateMismatch)
      else $error("mismatch flagged as clock slave");
endmodule
`default_nettype wire

// file: fpc_host_model.sv
// two-wire host controller model that drives the control port pins
`timescale 1ns/1ps
`default_nettype none
module fpc_host_model (
   input wire logic clk,
   input wire logic sdaLine,
   output logic scl,
   output logic sdaDrv
);
   // the line has a pull-up, so releasing it means driving 1 here
   initial
   begin
      scl = 1'h1;
      sdaDrv = 1'h1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // also serves as repeated start when entered with scl low
   task automatic startCond();
      sdaDrv <= 1'h1;
      hold(5);
      scl <= 1'h1;
      hold(10);
      sdaDrv <= 1'h0;
      hold(10);
      scl <= 1'h0;
      hold(5);
   endtask
   task automatic stopCond();
      sdaDrv <= 1'h0;
      hold(5);
      scl <= 1'h1;
      hold(10);
      sdaDrv <= 1'h1;
      hold(10);
   endtask
   // scl high and low last well over 8 clocks each
   task automatic xferBit(input logic b, output logic r);
      sdaDrv <= b;
      hold(5);
      scl <= 1'h1;
      hold(10);
      r = sdaLine;
      scl <= 1'h0;
      hold(5);
   endtask
   // msb first, then the ninth slot
   task automatic xferByte(input logic [7:0] d, input logic ackIn, output logic [7:0] r,
      output logic ackOut);
      for (int i = 7; i >= 0; i--) xferBit(d[i], r[i]);
      xferBit(ackIn, ackOut);
   endtask
endmodule
`default_nettype wire

// file: test_fractional_pll_config.sv
// self-checking bench for the fractional pll configuration block
`timescale 1ns/1ps
`default_nettype none
module test_fractional_pll_config;
   import fpc_pkg::*;
   localparam logic [6:0] devAddr = 7'h4A;
   logic clk, nrst, mclk, bclk, cm, tick, oeN, pOn, cfgOk, mism, osrOk;
   logic [FIN_W-1:0] fin;
   logic [DIV_W-1:0] processing_clock_divider, dac_clock_divider, nOsr, charge_pump_clock_divider;
   logic [24:0] kr;
   logic [31:0] pllHz, fsHz, cpHz;
   logic [11:0] dspR, modR;
   logic [13:0] dVal;
   wire logic scl, sdaDrv;
   wire logic sda = sdaDrv & oeN;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   fpc_host_model fpc_host_model_inst (.clk(clk), .sdaLine(sda), .scl(scl), .sdaDrv(sdaDrv));
   fpc_pll_config #(.DEV_ADDR(devAddr)) fpc_pll_config_inst (.clk_sys(clk), .nrst(nrst),
      .sclPin(scl), .sdaPin(sda), .sdaOut(), .sdaOeN(oeN), .masterClockPin(mclk),
      .bitClockPin(bclk), .gpioClockPin(1'h0), .pllInputClockHz(fin),
      .processingClockDivider(processing_clock_divider), .dacClockDivider(dac_clock_divider), .oversamplingClockDivider(nOsr),
      .chargePumpClockDivider(charge_pump_clock_divider), .clockMaster(cm), .pllOn(pOn), .referenceSourceSelect(),
      .preDividerP(), .integerMultiplierJ(), .fractionMultiplierD(dVal), .extraMultiplierR(),
      .pllRefTick(tick), .multiplierKR(kr), .pllOutputClockHz(pllHz), .sampleRateHz(fsHz),
      .dspRatio(dspR), .modRatio(modR), .chargePumpClockHz(cpHz), .configLegal(cfgOk),
      .rateMismatch(mism), .osrMatch(osrOk));
   // ----------------------------------------------------------------
   // compares and register access
   // ----------------------------------------------------------------
   task automatic checkByte(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic checkWord(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic k;
      fpc_host_model_inst.startCond();
      fpc_host_model_inst.xferByte({devAddr, 1'h0}, 1'h1, r, k);
      fpc_host_model_inst.xferByte(a, 1'h1, r, k);
      fpc_host_model_inst.xferByte(d, 1'h1, r, k);
      checkByte("write ack", 8'h00, {7'h0, k});
      fpc_host_model_inst.stopCond();
      fpc_host_model_inst.hold(5);
   endtask
   task automatic rdChk(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      logic k;
      fpc_host_model_inst.startCond();
      fpc_host_model_inst.xferByte({devAddr, 1'h0}, 1'h1, r, k);
      fpc_host_model_inst.xferByte(a, 1'h1, r, k);
      fpc_host_model_inst.startCond();
      fpc_host_model_inst.xferByte({devAddr, 1'h1}, 1'h1, r, k);
      fpc_host_model_inst.xferByte(8'hFF, 1'h1, r, k);
      fpc_host_model_inst.stopCond();
      checkByte(n, e, r);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic testReset();
      rdChk("enable", OFF_PLL_ON, 8'h01);
      rdChk("p", OFF_P_DIV, {4'h0, RST_P_DIV});
      rdChk("j", OFF_J_MUL, {2'h0, RST_J_MUL});
      rdChk("d high", OFF_D_HIGH, 8'h00);
      rdChk("r", OFF_R_MUL, {4'h0, RST_R_MUL});
      rdChk("unmapped", 8'h30, 8'h00);
   endtask
   task automatic testInteger();
      fin <= 26'd2048000;
      wrReg(OFF_J_MUL, 8'h30);
      checkWord("pll hz", 32'd98304000, pllHz);
      checkWord("kr", 32'd480000, {7'h0, kr});
      checkWord("fs", 32'd48000, fsHz);
      checkWord("dsp ratio", 32'd128, {20'h0, dspR});
      checkWord("mod ratio", 32'd128, {20'h0, modR});
      checkWord("cp hz", 32'd1536000, cpHz);
      checkWord("legal", 32'd1, {31'h0, cfgOk});
      checkWord("osr", 32'd1, {31'h0, osrOk});
      nOsr <= 7'd4;
      fin <= 26'd6144000;
      wrReg(OFF_P_DIV, 8'h03);
      wrReg(OFF_J_MUL, 8'h18);
      wrReg(OFF_R_MUL, 8'h01);
      checkWord("osr off", 32'd0, {31'h0, osrOk});
      checkWord("pll hz p3", 32'd98304000, pllHz);
      checkWord("kr r2", 32'd480000, {7'h0, kr});
   endtask
   task automatic testFraction();
      fin <= 26'd12000000;
      cm <= 1'h1;
      wrReg(OFF_P_DIV, 8'h01);
      wrReg(OFF_R_MUL, 8'h00);
      wrReg(OFF_J_MUL, 8'h07);
      wrReg(OFF_D_HIGH, 8'h04);
      wrReg(OFF_D_LOW, 8'hB0);
      checkWord("d", 32'd1200, {18'h0, dVal});
      checkWord("pll hz frac", 32'd85440000, pllHz);
      checkWord("legal frac", 32'd1, {31'h0, cfgOk});
      checkWord("mismatch", 32'd1, {31'h0, mism});
      cm <= 1'h0;
      fin <= 26'd8000000;
      wrReg(OFF_J_MUL, 8'h0C);
      checkWord("slave", 32'd0, {31'h0, mism});
      rdChk("status", OFF_STATUS, 8'h02);
   endtask
   task automatic testRefDivider();
      int n;
      n = 0;
      processing_clock_divider <= 7'd12;
      charge_pump_clock_divider <= 7'd1;
      wrReg(OFF_SRC_SEL, {1'h0, SRC_BCLK, 4'h0});
      wrReg(OFF_P_DIV, 8'h03);
      rdChk("source", OFF_SRC_SEL, 8'h10);
      // the unselected pin toggles twice as fast, so a wrong mux shows
      for (int i = 0; i < 150; i++)
      begin
         @(posedge clk);
         bclk <= (i < 144) ? i[3] : 1'h0;
         mclk <= i[2];
         if (tick === 1'h1) n++;
      end
      checkWord("ticks", 32'd3, n);
      checkWord("dsp ratio 12", 32'd170, {20'h0, dspR});
      checkWord("fs p3", 32'd15781, fsHz);
      checkWord("cp hz ncp1", 32'd2019968, cpHz);
   endtask
   task automatic testPllOff();
      wrReg(OFF_PLL_ON, 8'h00);
      checkWord("pll on", 32'd0, {31'h0, pOn});
      checkWord("pll hz off", 32'd0, pllHz);
      checkWord("legal off", 32'd1, {31'h0, cfgOk});
      rdChk("enable off", OFF_PLL_ON, 8'h00);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   // a full run needs about 15000 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         err_count++;
         print_verdict();
      end
   end
   initial
   begin
      nrst = 1'h0;
      mclk = 1'h0;
      bclk = 1'h0;
      cm = 1'h0;
      fin = '0;
      processing_clock_divider = 7'd16;
      dac_clock_divider = 7'd16;
      nOsr = 7'd8;
      charge_pump_clock_divider = 7'd4;
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      repeat (6) @(posedge clk);
      testReset();
      testInteger();
      testFraction();
      testRefDivider();
      testPllOff();
      print_verdict();
   end
endmodule
`default_nettype wire
